// ---- core/bbx_pkg.sv ----
// Behaviour
// - Taken branch loads pc+k+1 in 2 cycles, else 1; overflow tests V=1
// - Minus branch taken when N is one; plus branch taken when N is zero
// - Signed ge branch when N xor V is 0; signed lt when it is 1
// - Half-carry set branch when H is 1; clear branch when H is 0
// - Transfer set branch when T is 1; transfer clear branch when T is 0
// - Unsigned lower branch taken exactly when C is 1, same target
// - Set/clear I/O bit forces the bit, keeps flags, takes 2 cycles
// - Shifts fill zero; arith right keeps bit 7; Z,C,N,V set; 1 cycle
// - Rotate inserts old carry at vacated end; bit shifted out is carry
// - Bit store copies a bit to T; bit load copies T back, no flags
// - Dedicated or indexed flag ops set or clear one status bit
// - Interrupt enable sets global flag, disable clears it, 1 cycle each
package bbx_pkg;

  localparam int unsigned PC_W   = 16;
  localparam int unsigned K_W    = 7;
  localparam int unsigned IO_N   = 8;
  localparam int unsigned IO_AW  = 3;
  localparam int unsigned ADDR_W = 5;

  // Status register bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // Register map, one byte each
  localparam logic [ADDR_W-1:0] REG_STATUS  = 5'h00;
  localparam logic [ADDR_W-1:0] REG_PC_LO   = 5'h01;
  localparam logic [ADDR_W-1:0] REG_PC_HI   = 5'h02;
  localparam logic [ADDR_W-1:0] REG_WORK    = 5'h03;
  localparam logic [ADDR_W-1:0] REG_IO_BASE = 5'h08;

  localparam logic [7:0]      STATUS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST     = 16'h0000;
  localparam logic [7:0]      WORK_RST   = 8'h00;
  localparam logic [7:0]      IO_RST     = 8'h00;

  typedef enum logic [4:0] {
    OP_NOP      = 5'h00, OP_BR_LO    = 5'h01, OP_BR_MI    = 5'h02,
    OP_BR_PL    = 5'h03, OP_BR_GE    = 5'h04, OP_BR_LT    = 5'h05,
    OP_BR_HS    = 5'h06, OP_BR_HC    = 5'h07, OP_BR_TS    = 5'h08,
    OP_BR_TC    = 5'h09, OP_BR_VS    = 5'h0a, OP_SET_IO   = 5'h0b,
    OP_CLR_IO   = 5'h0c, OP_LSL      = 5'h0d, OP_LSR      = 5'h0e,
    OP_ROL      = 5'h0f, OP_ROR      = 5'h10, OP_ASR      = 5'h11,
    OP_STATUS_BIT_SET     = 5'h12, OP_STATUS_BIT_CLEAR     = 5'h13, OP_BST      = 5'h14,
    OP_BLD      = 5'h15, OP_SEC      = 5'h16, OP_CLC      = 5'h17,
    OP_SEN      = 5'h18, OP_CLN      = 5'h19, OP_SEZ      = 5'h1a,
    OP_CLZ      = 5'h1b, OP_SEI      = 5'h1c, OP_CLI      = 5'h1d,
    OP_SES      = 5'h1e, OP_CLS      = 5'h1f
  } bbx_op_t;

  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_SECOND = 1'b1
  } bbx_state_t;

  typedef struct packed {
    bbx_op_t          op;
    logic [K_W-1:0]   k;
    logic [2:0]       bidx;
    logic [IO_AW-1:0] io_addr;
  } bbx_instr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } bbx_bus_t;

endpackage

// ---- core/bbx_branch_cond.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbx_branch_cond (
  input  wire bbx_pkg::bbx_op_t i_op,
  input  wire logic [7:0]       i_status,
  output logic                  o_is_branch,
  output logic                  o_take
);
  import bbx_pkg::*;

  always_comb begin
    o_is_branch = 1'b1;
    o_take      = 1'b0;
    case (i_op)
      OP_BR_LO: o_take = i_status[FLAG_C];
      OP_BR_MI: o_take = i_status[FLAG_N];
      OP_BR_PL: o_take = ~i_status[FLAG_N];
      OP_BR_GE: o_take = ~(i_status[FLAG_N] ^ i_status[FLAG_V]);
      OP_BR_LT: o_take = i_status[FLAG_N] ^ i_status[FLAG_V];
      OP_BR_HS: o_take = i_status[FLAG_H];
      OP_BR_HC: o_take = ~i_status[FLAG_H];
      OP_BR_TS: o_take = i_status[FLAG_T];
      OP_BR_TC: o_take = ~i_status[FLAG_T];
      OP_BR_VS: o_take = i_status[FLAG_V];
      default:  o_is_branch = 1'b0;
    endcase
  end

endmodule // bbx_branch_cond
`default_nettype wire

// ---- core/bbx_shifter.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbx_shifter (
  input  wire bbx_pkg::bbx_op_t i_op,
  input  wire logic [7:0]       i_data,
  input  wire logic             i_carry,
  output logic                  o_is_shift,
  output logic [7:0]            o_result,
  output logic                  o_carry
);
  import bbx_pkg::*;

  always_comb begin
    o_is_shift = 1'b1;
    o_result   = i_data;
    o_carry    = i_carry;
    case (i_op)
      OP_LSL: begin
        o_result = {i_data[6:0], 1'b0};
        o_carry  = i_data[7];
      end
      OP_LSR: begin
        o_result = {1'b0, i_data[7:1]};
        o_carry  = i_data[0];
      end
      OP_ASR: begin
        o_result = {i_data[7], i_data[7:1]};
        o_carry  = i_data[0];
      end
      OP_ROL: begin
        o_result = {i_data[6:0], i_carry};
        o_carry  = i_data[7];
      end
      OP_ROR: begin
        o_result = {i_carry, i_data[7:1]};
        o_carry  = i_data[0];
      end
      default: o_is_shift = 1'b0;
    endcase
  end

endmodule // bbx_shifter
`default_nettype wire

// ---- core/bbx_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbx_exec (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_instr_valid,
  input  wire bbx_pkg::bbx_instr_t   i_instr,
  output logic                       o_instr_ready,
  output logic                       o_done,
  output logic [bbx_pkg::PC_W-1:0]   o_pc,
  output logic [7:0]                 o_status,
  input  wire bbx_pkg::bbx_bus_t     i_bus,
  output logic [7:0]                 o_rdata
);
  import bbx_pkg::*;

  bbx_state_t       st_r, st_nxt;
  logic [7:0]       status_r, status_nxt;
  logic [PC_W-1:0]  pc_r, pc_nxt;
  logic [7:0]       work_r, work_nxt;
  logic [7:0]       io_r [IO_N];
  logic [7:0]       io_nxt [IO_N];
  bbx_instr_t       pend_r, pend_nxt;
  logic [7:0]       rdata_r, rdata_nxt;

  logic             acc;
  logic             br_is;
  logic             br_take;
  logic             sh_is;
  logic [7:0]       sh_res;
  logic             sh_c;
  logic [PC_W-1:0]  pc_seq;
  logic [PC_W-1:0]  pc_tgt;

  // Status bit chosen by a flag instruction; indexed forms use the operand
  function automatic logic [2:0] flag_sel(input bbx_op_t op,
                                          input logic [2:0] bidx);
    case (op)
      OP_SEC, OP_CLC: flag_sel = 3'(FLAG_C);
      OP_SEN, OP_CLN: flag_sel = 3'(FLAG_N);
      OP_SEZ, OP_CLZ: flag_sel = 3'(FLAG_Z);
      OP_SES, OP_CLS: flag_sel = 3'(FLAG_S);
      OP_SEI, OP_CLI: flag_sel = 3'(FLAG_I);
      default:        flag_sel = bidx;
    endcase
  endfunction

  function automatic logic is_flag_op(input bbx_op_t op);
    case (op)
      OP_STATUS_BIT_SET, OP_STATUS_BIT_CLEAR, OP_SEC, OP_CLC, OP_SEN, OP_CLN, OP_SEZ, OP_CLZ,
      OP_SEI, OP_CLI, OP_SES, OP_CLS: is_flag_op = 1'b1;
      default:                        is_flag_op = 1'b0;
    endcase
  endfunction

  function automatic logic flag_value(input bbx_op_t op);
    case (op)
      OP_STATUS_BIT_SET, OP_SEC, OP_SEN, OP_SEZ, OP_SEI, OP_SES: flag_value = 1'b1;
      default:                                         flag_value = 1'b0;
    endcase
  endfunction

  bbx_branch_cond u_cond (
    .i_op        (i_instr.op),
    .i_status    (status_r),
    .o_is_branch (br_is),
    .o_take      (br_take)
  );

  bbx_shifter u_shift (
    .i_op       (i_instr.op),
    .i_data     (work_r),
    .i_carry    (status_r[FLAG_C]),
    .o_is_shift (sh_is),
    .o_result   (sh_res),
    .o_carry    (sh_c)
  );

  assign o_instr_ready = (st_r == ST_IDLE);
  assign acc           = i_instr_valid && o_instr_ready;
  // Second cycle of a two-cycle instruction, or any single-cycle one
  assign o_done        = (st_r == ST_SECOND) ||
                         (acc && !(br_is && br_take) &&
                          i_instr.op != OP_SET_IO && i_instr.op != OP_CLR_IO);
  assign pc_seq        = pc_r + 16'h0001;
  // Offset sign-extended so backward targets wrap correctly
  assign pc_tgt        = pc_seq + {{(PC_W-K_W){i_instr.k[K_W-1]}},
                                   i_instr.k};
  assign o_pc          = pc_r;
  assign o_status      = status_r;
  assign o_rdata       = rdata_r;

  always_comb begin
    st_nxt     = st_r;
    status_nxt = status_r;
    pc_nxt     = pc_r;
    work_nxt   = work_r;
    io_nxt     = io_r;
    pend_nxt   = pend_r;
    rdata_nxt  = 8'h00;
    // Bus access first so a same-cycle instruction update wins
    if (i_bus.rd) begin
      if (i_bus.addr == REG_STATUS) begin
        rdata_nxt = status_r;
      end else if (i_bus.addr == REG_PC_LO) begin
        rdata_nxt = pc_r[7:0];
      end else if (i_bus.addr == REG_PC_HI) begin
        rdata_nxt = pc_r[15:8];
      end else if (i_bus.addr == REG_WORK) begin
        rdata_nxt = work_r;
      end else if (i_bus.addr >= REG_IO_BASE &&
                   i_bus.addr < REG_IO_BASE + 5'(IO_N)) begin
        rdata_nxt = io_r[IO_AW'(i_bus.addr - REG_IO_BASE)];
      end
    end
    if (i_bus.wr) begin
      if (i_bus.addr == REG_STATUS) begin
        status_nxt = i_bus.wdata;
      end else if (i_bus.addr == REG_PC_LO) begin
        pc_nxt[7:0] = i_bus.wdata;
      end else if (i_bus.addr == REG_PC_HI) begin
        pc_nxt[15:8] = i_bus.wdata;
      end else if (i_bus.addr == REG_WORK) begin
        work_nxt = i_bus.wdata;
      end else if (i_bus.addr >= REG_IO_BASE &&
                   i_bus.addr < REG_IO_BASE + 5'(IO_N)) begin
        io_nxt[IO_AW'(i_bus.addr - REG_IO_BASE)] = i_bus.wdata;
      end
    end
    case (st_r)
      ST_IDLE: begin
        if (i_instr_valid) begin
          pend_nxt = i_instr;
          pc_nxt   = pc_seq;
          if (br_is) begin
            if (br_take) begin
              pc_nxt = pc_tgt;
              st_nxt = ST_SECOND;
            end
          end else if (sh_is) begin
            work_nxt           = sh_res;
            status_nxt[FLAG_C] = sh_c;
            status_nxt[FLAG_Z] = (sh_res == 8'h00);
            status_nxt[FLAG_N] = sh_res[7];
            status_nxt[FLAG_V] = sh_res[7] ^ sh_c;
          end else if (is_flag_op(i_instr.op)) begin
            status_nxt[flag_sel(i_instr.op, i_instr.bidx)] =
              flag_value(i_instr.op);
          end else begin
            case (i_instr.op)
              OP_SET_IO, OP_CLR_IO: st_nxt = ST_SECOND;
              OP_BST: status_nxt[FLAG_T] = work_r[i_instr.bidx];
              OP_BLD: work_nxt[i_instr.bidx] = status_r[FLAG_T];
              default: ;
            endcase
          end
        end
      end
      ST_SECOND: begin
        st_nxt = ST_IDLE;
        // Bit write lands in the second cycle; status is left alone
        if (pend_r.op == OP_SET_IO) begin
          io_nxt[pend_r.io_addr][pend_r.bidx] = 1'b1;
        end else if (pend_r.op == OP_CLR_IO) begin
          io_nxt[pend_r.io_addr][pend_r.bidx] = 1'b0;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r     <= ST_IDLE;
      status_r <= STATUS_RST;
      pc_r     <= PC_RST;
      work_r   <= WORK_RST;
      pend_r   <= '0;
      rdata_r  <= 8'h00;
    end else begin
      st_r     <= st_nxt;
      status_r <= status_nxt;
      pc_r     <= pc_nxt;
      work_r   <= work_nxt;
      pend_r   <= pend_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < IO_N; gi++) begin : g_io
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          io_r[gi] <= IO_RST;
        end else begin
          io_r[gi] <= io_nxt[gi];
        end
      end
    end
  endgenerate

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic quiet;
  assign quiet = !i_bus.wr;

  sequence s_stall_one;
    !o_instr_ready && o_done ##1 o_instr_ready;
  endsequence

  a_branch_taken: assert property (
    acc && br_is && br_take && quiet |=> o_pc == $past(pc_tgt) ##0 s_stall_one)
    else $error("taken branch target or timing wrong");

  a_branch_fall: assert property (
    acc && br_is && !br_take && quiet |-> o_done ##1
      (o_instr_ready && o_pc == $past(o_pc) + 16'h0001))
    else $error("untaken branch not one cycle");

  a_branch_back: assert property (
    acc && br_is && br_take && quiet && i_instr.k[K_W-1] |=>
      o_pc <= $past(o_pc))
    else $error("negative offset did not go backward");

  a_minus_plus: assert property (
    acc && (i_instr.op == OP_BR_MI || i_instr.op == OP_BR_PL) |->
      br_take == (status_r[FLAG_N] == (i_instr.op == OP_BR_MI)))
    else $error("minus/plus condition wrong");

  a_signed_cmp: assert property (
    acc && (i_instr.op == OP_BR_GE || i_instr.op == OP_BR_LT) |->
      br_take == ((status_r[FLAG_N] ^ status_r[FLAG_V]) ==
                  (i_instr.op == OP_BR_LT)))
    else $error("signed compare branch wrong");

  a_half_transfer: assert property (
    acc && (i_instr.op == OP_BR_HS || i_instr.op == OP_BR_TC) |->
      br_take == (i_instr.op == OP_BR_HS ? status_r[FLAG_H]
                                         : !status_r[FLAG_T]))
    else $error("half carry or transfer branch wrong");

  a_lower_ovf: assert property (
    acc && (i_instr.op == OP_BR_LO || i_instr.op == OP_BR_VS) |->
      br_take == (i_instr.op == OP_BR_LO ? status_r[FLAG_C]
                                         : status_r[FLAG_V]))
    else $error("lower or overflow branch wrong");

  a_io_bit: assert property (
    acc && i_instr.op == OP_SET_IO && quiet ##1 quiet |->
      ##1 io_r[$past(i_instr.io_addr, 2)][$past(i_instr.bidx, 2)] &&
      status_r == $past(status_r, 2))
    else $error("set io bit wrong");

  a_io_clear: assert property (
    acc && i_instr.op == OP_CLR_IO && quiet ##1 quiet |->
      ##1 !io_r[$past(i_instr.io_addr, 2)][$past(i_instr.bidx, 2)] &&
      status_r == $past(status_r, 2))
    else $error("clear io bit wrong");

  a_shift_left: assert property (
    acc && i_instr.op == OP_LSL && quiet |=>
      work_r == {$past(work_r[6:0]), 1'b0} &&
      status_r[FLAG_C] == $past(work_r[7]) && o_instr_ready)
    else $error("logical shift left wrong");

  // Sign bit must survive the shift, or signed halving breaks
  a_arith_right: assert property (
    acc && i_instr.op == OP_ASR && quiet |=>
      work_r == {$past(work_r[7]), $past(work_r[7:1])} &&
      status_r[FLAG_Z] == (work_r == 8'h00) &&
      status_r[FLAG_V] == (work_r[7] ^ status_r[FLAG_C]))
    else $error("arithmetic shift right wrong");

  a_rotate_right: assert property (
    acc && i_instr.op == OP_ROR && quiet |=>
      work_r == {$past(status_r[FLAG_C]), $past(work_r[7:1])} &&
      status_r[FLAG_C] == $past(work_r[0]))
    else $error("rotate right wrong");

  a_bit_load: assert property (
    acc && i_instr.op == OP_BLD && quiet |=>
      work_r[$past(i_instr.bidx)] == status_r[FLAG_T] &&
      status_r == $past(status_r))
    else $error("bit load wrong");

  a_bit_store: assert property (
    acc && i_instr.op == OP_BST && quiet |=>
      status_r[FLAG_T] == $past(work_r[i_instr.bidx]) &&
      work_r == $past(work_r))
    else $error("bit store wrong");

  a_irq_flag: assert property (
    acc && (i_instr.op == OP_SEI || i_instr.op == OP_CLI) && quiet |=>
      status_r[FLAG_I] == $past(i_instr.op == OP_SEI) &&
      status_r[6:0] == $past(status_r[6:0]) && o_instr_ready)
    else $error("interrupt flag instruction wrong");

  a_carry_flag: assert property (
    acc && (i_instr.op == OP_SEC || i_instr.op == OP_CLC) && quiet |=>
      status_r[FLAG_C] == $past(i_instr.op == OP_SEC) &&
      status_r[7:1] == $past(status_r[7:1]))
    else $error("carry flag instruction wrong");

  a_index_flag: assert property (
    acc && (i_instr.op == OP_STATUS_BIT_SET || i_instr.op == OP_STATUS_BIT_CLEAR) && quiet |=>
      status_r[$past(i_instr.bidx)] == $past(i_instr.op == OP_STATUS_BIT_SET))
    else $error("indexed flag instruction wrong");

endmodule // bbx_exec
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb;
  import bbx_pkg::*;
  logic            i_clk;
  logic            i_rst;
  logic            i_instr_valid;
  bbx_instr_t      i_instr;
  bbx_bus_t        i_bus;
  logic            o_instr_ready;
  logic            o_done;
  logic [PC_W-1:0] o_pc;
  logic [7:0]      o_status;
  logic [7:0]      o_rdata;
  int              err_count;
  int              checks_done;
  bbx_op_t         brs [10] = '{OP_BR_LO, OP_BR_MI, OP_BR_PL, OP_BR_GE,
    OP_BR_LT, OP_BR_HS, OP_BR_HC, OP_BR_TS, OP_BR_TC, OP_BR_VS};
  bbx_op_t         shs [5] = '{OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR};
  bbx_op_t         fls [10] = '{OP_SEC, OP_CLC, OP_SEN, OP_CLN, OP_SEZ,
    OP_CLZ, OP_SEI, OP_CLI, OP_SES, OP_CLS};
  int              fbit [10] = '{FLAG_C, FLAG_C, FLAG_N, FLAG_N, FLAG_Z,
    FLAG_Z, FLAG_I, FLAG_I, FLAG_S, FLAG_S};
  logic [7:0]      sts [4] = '{8'h00, 8'hff, 8'h04, 8'h08};
  logic [6:0]      kv [4] = '{7'h3f, 7'h40, 7'h7d, 7'h01};
  logic [7:0]      dv [3] = '{8'h81, 8'h01, 8'h40};

  bbx_exec bbx_exec_inst (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_instr_valid (i_instr_valid),
    .i_instr       (i_instr),
    .o_instr_ready (o_instr_ready),
    .o_done        (o_done),
    .o_pc          (o_pc),
    .o_status      (o_status),
    .i_bus         (i_bus),
    .o_rdata       (o_rdata)
  );

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Every task starts and ends just after a rising edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_instr_valid <= 1'b0;
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    i_instr_valid <= 1'b0;
    i_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    i_bus <= '0;
    #1 `CHK(o_rdata, e);
    // Nothing moves status or pc between the read and here
    if (a == REG_STATUS) `CHK(o_status, e);
    if (a == REG_PC_LO) `CHK(o_pc[7:0], e);
    if (a == REG_PC_HI) `CHK(o_pc[15:8], e);
    @(posedge i_clk);
  endtask

  // Valid stays up through the second cycle, so a retake would show
  task automatic ex(input bbx_op_t op, input logic [6:0] k,
                    input logic [2:0] b, input int cyc);
    i_instr_valid <= 1'b1;
    i_instr <= '{op, k, b, k[2:0]};
    i_bus <= '0;
    #1 `CHK(o_instr_ready, 1'b1);
    `CHK(o_done, cyc == 1);
    @(posedge i_clk);
    if (cyc == 2) begin
      #1 `CHK(o_instr_ready, 1'b0);
      `CHK(o_done, 1'b1);
      @(posedge i_clk);
    end
  endtask

  function automatic logic take(bbx_op_t op, logic [7:0] s);
    case (op)
      OP_BR_LO: return s[FLAG_C];
      OP_BR_MI: return s[FLAG_N];
      OP_BR_PL: return !s[FLAG_N];
      OP_BR_GE: return !(s[FLAG_N] ^ s[FLAG_V]);
      OP_BR_LT: return s[FLAG_N] ^ s[FLAG_V];
      OP_BR_HS: return s[FLAG_H];
      OP_BR_HC: return !s[FLAG_H];
      OP_BR_TS: return s[FLAG_T];
      OP_BR_TC: return !s[FLAG_T];
      default:  return s[FLAG_V];
    endcase
  endfunction

  // Returns the new carry above the 8-bit result
  function automatic logic [8:0] shf(bbx_op_t op, logic [7:0] d, logic c);
    case (op)
      OP_LSL:  return {d, 1'b0};
      OP_LSR:  return {d[0], 1'b0, d[7:1]};
      OP_ROL:  return {d, c};
      OP_ROR:  return {d[0], c, d[7:1]};
      default: return {d[0], d[7], d[7:1]};
    endcase
  endfunction

  initial begin
    logic        t;
    logic [15:0] pe;
    logic [8:0]  r;
    logic [7:0]  st;
    logic [7:0]  e;
    logic [7:0]  w;
    bbx_op_t     op;
    int          b;
    i_rst = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = '0;
    i_bus = '0;
    err_count = 0;
    checks_done = 0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(REG_STATUS, STATUS_RST);
    rd_chk(REG_PC_HI, PC_RST[15:8]);
    rd_chk(REG_WORK, WORK_RST);
    rd_chk(REG_IO_BASE + 5'h7, IO_RST);
    wr(5'h1f, 8'hff);
    rd_chk(5'h1f, 8'h00);
    for (int i = 0; i < 10; i++) begin
      for (int s = 0; s < 4; s++) begin
        wr(REG_STATUS, sts[s]);
        wr(REG_PC_LO, 8'h00);
        wr(REG_PC_HI, 8'h01);
        t = take(brs[i], sts[s]);
        ex(brs[i], kv[s], 3'h0, t ? 2 : 1);
        pe = t ? 16'h0101 + {{9{kv[s][6]}}, kv[s]} : 16'h0101;
        rd_chk(REG_PC_LO, pe[7:0]);
        rd_chk(REG_PC_HI, pe[15:8]);
        rd_chk(REG_STATUS, sts[s]);
      end
    end
    for (int i = 0; i < 8; i++) begin
      wr(REG_IO_BASE + 5'(i), 8'h5a);
      wr(REG_STATUS, 8'h3c);
      ex(OP_SET_IO, 7'(i), 3'(7 - i), 2);
      e = 8'h5a | (8'h01 << (7 - i));
      rd_chk(REG_IO_BASE + 5'(i), e);
      ex(OP_CLR_IO, 7'(i), 3'(i), 2);
      rd_chk(REG_IO_BASE + 5'(i), e & ~(8'h01 << i));
      rd_chk(REG_STATUS, 8'h3c);
    end
    for (int i = 0; i < 5; i++) begin
      for (int n = 0; n < 6; n++) begin
        // Z, N, V start set so a stale flag is caught
        st = 8'h7e | 8'(n % 2);
        r = shf(shs[i], dv[n / 2], st[0]);
        e = {st[7:4], r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
        wr(REG_WORK, dv[n / 2]);
        wr(REG_STATUS, st);
        ex(shs[i], 7'h00, 3'h0, 1);
        rd_chk(REG_WORK, r[7:0]);
        rd_chk(REG_STATUS, e);
      end
    end
    for (int i = 0; i < 8; i++) begin
      st = (8'ha5 >> i) & 8'h01 ? 8'h00 : 8'hff;
      e = st ^ 8'h40;
      w = 8'ha5;
      w[3'(i + 1)] = w[i];
      wr(REG_WORK, 8'ha5);
      wr(REG_STATUS, st);
      ex(OP_BST, 7'h00, 3'(i), 1);
      rd_chk(REG_STATUS, e);
      ex(OP_BLD, 7'h00, 3'(i + 1), 1);
      rd_chk(REG_WORK, w);
      rd_chk(REG_STATUS, e);
    end
    for (int n = 0; n < 26; n++) begin
      op = n < 10 ? fls[n] : (n % 2 ? OP_STATUS_BIT_CLEAR : OP_STATUS_BIT_SET);
      b = n < 10 ? fbit[n] : (n - 10) / 2;
      st = n % 2 ? 8'hff : 8'h00;
      wr(REG_STATUS, st);
      ex(op, 7'h00, 3'(b), 1);
      rd_chk(REG_STATUS, st ^ (8'h01 << b));
    end
    // Back-to-back single-cycle ops, then a taken branch right behind
    wr(REG_STATUS, 8'h00);
    ex(OP_SEC, 7'h00, 3'h0, 1);
    ex(OP_SEZ, 7'h00, 3'h0, 1);
    ex(OP_BR_LO, 7'h7e, 3'h0, 2);
    rd_chk(REG_STATUS, 8'h03);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    complete_run();
  end
endmodule // tb
`default_nettype wire
